//--- cmx_pkg.sv
/*
  Package for the comparator mode and input-select register bank:
  special-function register addresses, field positions, reset values,
  input-select codes and the bus struct.
  Assumes an 8-bit special-function register bus on the system clock.
*/
// Notes on behaviour
// RQ1 - Unused bits 7:6 and 3:2 read as zero; writes to them are ignored.
// RQ2 - Mode bit 5 enables the second comparator's rising-edge interrupt.
// RQ3 - Mode bit 4 enables the second comparator's falling-edge interrupt.
// RQ4 - Mode bits 1:0 pick response time: 00 fastest, 11 slowest power.
// RQ5 - First comparator negative input: P1.1, P1.5, P2.1, P2.5 by code.
// RQ6 - First comparator positive input: P1.0, P1.4, P2.0, P2.4 by code.
// RQ7 - Second comparator negative input: P1.3, P1.7, P2.3, P2.7 by code.
// RQ8 - Second comparator positive input: P1.2, P1.6, P2.1, P2.6 by code.
// RQ9 - Software sets chosen input pins analog and skipped by the crossbar.
// RQ10 - Output changes set sticky rise and fall flags until software clears.
// RQ11 - Interrupt requested while an enabled edge flag is set.
package cmx_pkg;
  localparam logic [7:0] ADDR_CMP1_MODE   = 8'h9C;
  localparam logic [7:0] ADDR_CMP1_INSEL  = 8'h9E;
  localparam logic [7:0] ADDR_CMP0_INSEL  = 8'h9F;
  localparam logic [7:0] ADDR_CMP1_CTRL   = 8'h9A;
  localparam logic [7:0] ADDR_CMP0_CTRL   = 8'h9B;
  localparam int         BIT_RISE_IE      = 5;
  localparam int         BIT_FALL_IE      = 4;
  localparam int         BIT_RISE_FLAG    = 5;
  localparam int         BIT_FALL_FLAG    = 4;
  localparam int         BIT_OUT_STATE    = 6;
  localparam int         SEL_NEG_LSB      = 4;
  localparam int         SEL_POS_LSB      = 0;
  localparam logic [7:0] MODE_WMASK       = 8'h33;
  localparam logic [7:0] INSEL_WMASK      = 8'h33;
  localparam logic [1:0] MODE_RESET       = 2'h2;
  localparam logic [1:0] SEL_RESET        = 2'h0;

  // Pin index: (port-1)*8 + bit, over P1 and P2
  localparam logic [3:0] PIN_P1_0 = 4'h0;
  localparam logic [3:0] PIN_P2_0 = 4'h8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmx_bus_t;

  typedef struct packed {
    logic [3:0] pos_pin;
    logic [3:0] neg_pin;
  } cmx_route_t;
endpackage : cmx_pkg

//--- cmx_edge.sv
/*
  Edge flag unit for one comparator: synchronises the comparator output,
  keeps sticky rise and fall flags and raises a request when enabled.
  Assumes the comparator output is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module cmx_edge (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic cmp_async,
  input  wire logic clr_rise,
  input  wire logic clr_fall,
  input  wire logic rise_ie,
  input  wire logic fall_ie,
  output logic      cmp_state,
  output logic      rise_flag,
  output logic      fall_flag,
  output logic      irq
);
  import cmx_pkg::*;

  logic sync_a;
  logic sync_b;
  logic prev;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= cmp_async;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign cmp_state = prev;

  // Set beats clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rise_flag <= 1'b0;
      fall_flag <= 1'b0;
    end else begin
      rise_flag <= (sync_b & ~prev) | (rise_flag & ~clr_rise); // RQ10
      fall_flag <= (~sync_b & prev) | (fall_flag & ~clr_fall); // RQ10
    end
  end

  function automatic logic next_rise_req();
    return rise_flag & rise_ie;
  endfunction : next_rise_req

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= (next_rise_req()) | (fall_flag & fall_ie); // RQ11
    end
  end

endmodule : cmx_edge
`default_nettype wire

//--- cmx_regs.sv
/*
  Comparator mode and input-select register bank: three SFRs plus the
  edge-flag bits of both comparator control registers, input routing
  outputs and the comparator interrupt requests.
  Assumes single-cycle SFR strobes on clk_sys; the reset is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module cmx_regs (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire cmx_pkg::cmx_bus_t sfr_bus,
  input  wire logic              cmp0_out_async,
  input  wire logic              cmp1_out_async,
  output logic [7:0]             sfr_rdata,
  output logic                   sfr_hit,
  output cmx_pkg::cmx_route_t    cmp0_route,
  output cmx_pkg::cmx_route_t    cmp1_route,
  output logic [1:0]             cmp1_response_mode,
  output logic                   cmp0_irq,
  output logic                   cmp1_irq
);
  import cmx_pkg::*;

  // Which register a bus access addresses
  typedef enum logic [2:0] {
    REG_NONE,
    REG_MODE,
    REG_IN1,
    REG_IN0,
    REG_CT1,
    REG_CT0
  } cmx_reg_t;

  logic       cmp1_rise_irq_enable;
  logic       cmp1_fall_irq_enable;
  logic [1:0] neg_input_select;
  logic [1:0] pos_input_select;
  logic [1:0] cmp1_neg_input_select;
  logic [1:0] cmp1_pos_input_select;
  logic       cmp1_rise_flag;
  logic       cmp1_fall_flag;
  logic       cmp0_rise_flag;
  logic       cmp0_fall_flag;
  logic       cmp0_state;
  logic       cmp1_state;
  logic       wr_mode;
  logic       wr_in0;
  logic       wr_in1;
  logic       wr_ct0;
  logic       wr_ct1;
  logic       clr0_rise;
  logic       clr0_fall;
  logic       clr1_rise;
  logic       clr1_fall;
  logic [7:0] mode_rd;
  logic [7:0] insel0_rd;
  logic [7:0] insel1_rd;
  logic [7:0] ctl0_rd;
  logic [7:0] ctl1_rd;
  cmx_reg_t   wr_sel;
  cmx_reg_t   rd_sel;

  function automatic logic [3:0] pin_of(input logic [3:0] base, input logic [1:0] code);
    // Code bit 0 steps four pins, bit 1 moves from port 1 to port 2
    return base + {code[1], code[0], 2'h0};
  endfunction : pin_of

  function automatic cmx_reg_t decode_addr(input logic [7:0] addr);
    cmx_reg_t sel;
    if (addr == ADDR_CMP1_MODE) begin
      sel = REG_MODE;
    end else if (addr == ADDR_CMP1_INSEL) begin
      sel = REG_IN1;
    end else if (addr == ADDR_CMP0_INSEL) begin
      sel = REG_IN0;
    end else if (addr == ADDR_CMP1_CTRL) begin
      sel = REG_CT1;
    end else if (addr == ADDR_CMP0_CTRL) begin
      sel = REG_CT0;
    end else begin
      sel = REG_NONE;
    end
    return sel;
  endfunction : decode_addr

  function automatic logic [7:0] sel_value(input logic [1:0] neg, input logic [1:0] pos);
    logic [7:0] v;
    v                   = 8'h00;
    v[SEL_NEG_LSB +: 2] = neg;
    v[SEL_POS_LSB +: 2] = pos;
    return v;
  endfunction : sel_value

  function automatic logic [7:0] ctl_value(input logic state, input logic rise,
                                           input logic fall);
    logic [7:0] v;
    v                = 8'h00;
    v[BIT_OUT_STATE] = state;
    v[BIT_RISE_FLAG] = rise;
    v[BIT_FALL_FLAG] = fall;
    return v;
  endfunction : ctl_value

  assign wr_sel  = sfr_bus.wr ? decode_addr(sfr_bus.addr) : REG_NONE;
  assign rd_sel  = sfr_bus.rd ? decode_addr(sfr_bus.addr) : REG_NONE;
  assign wr_mode = (wr_sel == REG_MODE);
  assign wr_in1  = (wr_sel == REG_IN1);
  assign wr_in0  = (wr_sel == REG_IN0);
  assign wr_ct1  = (wr_sel == REG_CT1);
  assign wr_ct0  = (wr_sel == REG_CT0);

  // Writing 0 to a flag bit clears it; writing 1 leaves it
  assign clr0_rise = wr_ct0 && !sfr_bus.wdata[BIT_RISE_FLAG]; // RQ10
  assign clr0_fall = wr_ct0 && !sfr_bus.wdata[BIT_FALL_FLAG]; // RQ10
  assign clr1_rise = wr_ct1 && !sfr_bus.wdata[BIT_RISE_FLAG]; // RQ10
  assign clr1_fall = wr_ct1 && !sfr_bus.wdata[BIT_FALL_FLAG]; // RQ10

  // Mode register: only bits 5, 4 and 1:0 are stored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmp1_rise_irq_enable <= 1'b0;
      cmp1_fall_irq_enable <= 1'b0;
      cmp1_response_mode   <= MODE_RESET;
    end else if (wr_mode) begin
      cmp1_rise_irq_enable <= sfr_bus.wdata[BIT_RISE_IE]; // RQ2
      cmp1_fall_irq_enable <= sfr_bus.wdata[BIT_FALL_IE]; // RQ3
      cmp1_response_mode   <= sfr_bus.wdata[1:0]; // RQ4
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      neg_input_select <= SEL_RESET;
      pos_input_select <= SEL_RESET;
    end else if (wr_in0) begin
      neg_input_select <= sfr_bus.wdata[SEL_NEG_LSB +: 2]; // RQ1
      pos_input_select <= sfr_bus.wdata[SEL_POS_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmp1_neg_input_select <= SEL_RESET;
      cmp1_pos_input_select <= SEL_RESET;
    end else if (wr_in1) begin
      cmp1_neg_input_select <= sfr_bus.wdata[SEL_NEG_LSB +: 2]; // RQ1
      cmp1_pos_input_select <= sfr_bus.wdata[SEL_POS_LSB +: 2];
    end
  end

  // Pin routing; P1.n = index n, P2.n = index 8+n
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmp0_route <= '0;
      cmp1_route <= '0;
    end else begin
      cmp0_route.neg_pin <= pin_of(PIN_P1_0 + 4'h1, neg_input_select); // RQ5
      cmp0_route.pos_pin <= pin_of(PIN_P1_0, pos_input_select); // RQ6
      cmp1_route.neg_pin <= pin_of(PIN_P1_0 + 4'h3, cmp1_neg_input_select); // RQ7
      // Code 10 selects P2.1, unlike the regular pattern
      case (cmp1_pos_input_select) // RQ8
        2'h0:    cmp1_route.pos_pin <= PIN_P1_0 + 4'h2;
        2'h1:    cmp1_route.pos_pin <= PIN_P1_0 + 4'h6;
        2'h2:    cmp1_route.pos_pin <= PIN_P2_0 + 4'h1;
        default: cmp1_route.pos_pin <= PIN_P2_0 + 4'h6;
      endcase
    end
  end

  cmx_edge u_edge0 (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .cmp_async (cmp0_out_async),
    .clr_rise  (clr0_rise),
    .clr_fall  (clr0_fall),
    .rise_ie   (1'b1),
    .fall_ie   (1'b1),
    .cmp_state (cmp0_state),
    .rise_flag (cmp0_rise_flag),
    .fall_flag (cmp0_fall_flag),
    .irq       (cmp0_irq)
  );

  cmx_edge u_edge1 (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .cmp_async (cmp1_out_async),
    .clr_rise  (clr1_rise),
    .clr_fall  (clr1_fall),
    .rise_ie   (cmp1_rise_irq_enable), // RQ2
    .fall_ie   (cmp1_fall_irq_enable), // RQ3
    .cmp_state (cmp1_state),
    .rise_flag (cmp1_rise_flag),
    .fall_flag (cmp1_fall_flag),
    .irq       (cmp1_irq)
  );

  // Read values; unused bits read zero
  assign mode_rd   = {2'h0, cmp1_rise_irq_enable, cmp1_fall_irq_enable, 2'h0,
                      cmp1_response_mode}; // RQ1
  assign insel1_rd = sel_value(cmp1_neg_input_select, cmp1_pos_input_select); // RQ1
  assign insel0_rd = sel_value(neg_input_select, pos_input_select); // RQ1
  assign ctl1_rd   = ctl_value(cmp1_state, cmp1_rise_flag, cmp1_fall_flag); // RQ10
  assign ctl0_rd   = ctl_value(cmp0_state, cmp0_rise_flag, cmp0_fall_flag); // RQ10

  // Registered read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else if (rd_sel == REG_MODE) begin
      sfr_rdata <= mode_rd;
      sfr_hit   <= 1'b1;
    end else if (rd_sel == REG_IN1) begin
      sfr_rdata <= insel1_rd;
      sfr_hit   <= 1'b1;
    end else if (rd_sel == REG_IN0) begin
      sfr_rdata <= insel0_rd;
      sfr_hit   <= 1'b1;
    end else if (rd_sel == REG_CT1) begin
      sfr_rdata <= ctl1_rd;
      sfr_hit   <= 1'b1;
    end else if (rd_sel == REG_CT0) begin
      sfr_rdata <= ctl0_rd;
      sfr_hit   <= 1'b1;
    end else begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end
  end
endmodule : cmx_regs
`default_nettype wire

//--- cmx_regs_monitor.sv
/*
  Port checker for cmx_regs.
  Bound to every cmx_regs instance; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cmx_regs_monitor (
  input wire logic                clk_sys,
  input wire logic                rstn,
  input wire cmx_pkg::cmx_bus_t   sfr_bus,
  input wire logic [7:0]          sfr_rdata,
  input wire cmx_pkg::cmx_route_t cmp0_route,
  input wire cmx_pkg::cmx_route_t cmp1_route,
  input wire logic [1:0]          cmp1_response_mode,
  input wire logic                cmp0_irq,
  input wire logic                cmp1_irq
);
  import cmx_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [7:0] a;
  logic [7:0] d;
  logic [7:0] d1;
  logic [7:0] d2;
  logic [7:0] d3;
  logic       w1;
  logic       w0;
  assign a = sfr_bus.addr;
  assign d = sfr_bus.wdata;
  assign w1 = sfr_bus.wr && (a == ADDR_CMP1_CTRL || a == ADDR_CMP1_MODE);
  assign w0 = sfr_bus.wr && a == ADDR_CMP0_CTRL;
  // Write data delayed to line up with register and route latency
  always_ff @(posedge clk_sys) begin
    d1 <= d;
    d2 <= d1;
    d3 <= d2;
  end
  property p_unused;
    sfr_bus.rd && (a == ADDR_CMP1_MODE || a == ADDR_CMP1_INSEL || a == ADDR_CMP0_INSEL)
      |=> (sfr_rdata & 8'hCC) == 8'h00;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused bits read nonzero");
  property p_mode_rb;
    sfr_bus.wr && a == ADDR_CMP1_MODE ##1 !sfr_bus.wr ##1 sfr_bus.rd && a == ADDR_CMP1_MODE
      |=> sfr_rdata == (d3 & 8'h33);
  endproperty
  a_mode_rb: assert property (p_mode_rb)
    else $error("mode register readback wrong");
  property p_mode;
    sfr_bus.wr && a == ADDR_CMP1_MODE |=> cmp1_response_mode == d1[1:0];
  endproperty
  a_mode: assert property (p_mode)
    else $error("response mode not updated");
  property p_route0;
    sfr_bus.wr && a == ADDR_CMP0_INSEL
      |=> ##1 cmp0_route == {d2[1:0], 2'h0, d2[5:4], 2'h1};
  endproperty
  a_route0: assert property (p_route0)
    else $error("first comparator route wrong");
  property p_route1;
    sfr_bus.wr && a == ADDR_CMP1_INSEL |=> ##1 cmp1_route ==
      {(d2[1:0] == 2'h2) ? 4'h9 : {d2[1:0], 2'h2}, d2[5:4], 2'h3};
  endproperty
  a_route1: assert property (p_route1)
    else $error("second comparator route wrong");
  property p_mask;
    sfr_bus.wr && a == ADDR_CMP1_MODE && d[5:4] == 2'h0 |=> ##1 !cmp1_irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt with both enables off");
  property p_hold1;
    cmp1_irq && !w1 && !$past(w1) && !$past(w1, 2) |=> cmp1_irq;
  endproperty
  a_hold1: assert property (p_hold1)
    else $error("second comparator request dropped");
  property p_hold0;
    cmp0_irq && !w0 && !$past(w0) && !$past(w0, 2) |=> cmp0_irq;
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("first comparator request dropped");
endmodule : cmx_regs_monitor
bind cmx_regs cmx_regs_monitor u_mon (.clk_sys, .rstn, .sfr_bus, .sfr_rdata, .cmp0_route,
  .cmp1_route, .cmp1_response_mode, .cmp0_irq, .cmp1_irq);
`default_nettype wire

//--- tb_comparator_mode_and_input_select.sv
/*
  Self-checking bench for cmx_regs.
  Drives the register bus and both comparator outputs directly.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_mode_and_input_select;
  import cmx_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rstn    = 1'b0;
  cmx_bus_t   bus     = '0;
  // Comparator outputs are driven directly, as if from analog, crossbar-skipped pins
  logic       c0      = 1'b0;
  logic       c1      = 1'b0;
  logic [7:0] rdata;
  logic       hit;
  logic [7:0] q;
  logic       h;
  cmx_route_t r0;
  cmx_route_t r1;
  logic [1:0] md;
  logic       i0;
  logic       i1;
  int         mismatches = 0;
  int         n_tests = 0;
  logic [3:0] p0 [4] = '{4'h0, 4'h4, 4'h8, 4'hC};
  logic [3:0] n0 [4] = '{4'h1, 4'h5, 4'h9, 4'hD};
  logic [3:0] p1 [4] = '{4'h2, 4'h6, 4'h9, 4'hE};
  logic [3:0] n1 [4] = '{4'h3, 4'h7, 4'hB, 4'hF};
  always #2 clk_sys = ~clk_sys;
  cmx_regs dut (.clk_sys, .rstn, .sfr_bus(bus), .cmp0_out_async(c0), .cmp1_out_async(c1),
    .sfr_rdata(rdata), .sfr_hit(hit), .cmp0_route(r0), .cmp1_route(r1),
    .cmp1_response_mode(md), .cmp0_irq(i0), .cmp1_irq(i1));
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One strobe per two cycles so the bus is never driven twice in a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    bus = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    q = rdata;
    h = hit;
    bus = '0;
  endtask : acc
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("rdata", e, q);
    chk("hit", 8'h01, {7'h0, h});
  endtask : rdchk
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : waitc
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    rdchk(ADDR_CMP1_MODE, 8'h02);
    rdchk(ADDR_CMP1_INSEL, 8'h00);
    rdchk(ADDR_CMP0_INSEL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, ADDR_CMP0_INSEL, 8'hCC | 8'(c * 17));
      rdchk(ADDR_CMP0_INSEL, 8'(c * 17));
      chk("route0", {p0[c], n0[c]}, r0);
      acc(1'b1, ADDR_CMP1_INSEL, 8'hCC | 8'(c * 17));
      rdchk(ADDR_CMP1_INSEL, 8'(c * 17));
      chk("route1", {p1[c], n1[c]}, r1);
      acc(1'b1, ADDR_CMP1_MODE, 8'hCC | 8'(c));
      rdchk(ADDR_CMP1_MODE, 8'(c));
      chk("mode", 8'(c), {6'h0, md});
    end
    acc(1'b1, ADDR_CMP1_MODE, 8'h30);
    c1 = 1'b1;
    waitc(6);
    chk("irq1", 8'h01, {7'h0, i1});
    rdchk(ADDR_CMP1_CTRL, 8'h60);
    c1 = 1'b0;
    waitc(6);
    rdchk(ADDR_CMP1_CTRL, 8'h30);
    chk("irq1", 8'h01, {7'h0, i1});
    acc(1'b1, ADDR_CMP1_CTRL, 8'h00);
    waitc(3);
    chk("irq1", 8'h00, {7'h0, i1});
    rdchk(ADDR_CMP1_CTRL, 8'h00);
    acc(1'b1, ADDR_CMP1_MODE, 8'h10);
    c1 = 1'b1;
    waitc(6);
    chk("irq1", 8'h00, {7'h0, i1});
    rdchk(ADDR_CMP1_CTRL, 8'h60);
    acc(1'b1, ADDR_CMP1_CTRL, 8'h00);
    acc(1'b1, ADDR_CMP1_MODE, 8'h20);
    c1 = 1'b0;
    waitc(6);
    chk("irq1", 8'h00, {7'h0, i1});
    rdchk(ADDR_CMP1_CTRL, 8'h10);
    c0 = 1'b1;
    waitc(6);
    chk("irq0", 8'h01, {7'h0, i0});
    rdchk(ADDR_CMP0_CTRL, 8'h60);
    acc(1'b1, ADDR_CMP0_CTRL, 8'h00);
    waitc(3);
    chk("irq0", 8'h00, {7'h0, i0});
    // Unmapped address answers zero and no hit
    acc(1'b0, 8'h9D, 8'h00);
    chk("rdata", 8'h00, q);
    chk("hit", 8'h00, {7'h0, h});
    tally_and_finish();
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_comparator_mode_and_input_select
`default_nettype wire
